/* rtl/hct_transfer_control.sv */
// Local design decision: the Avalon-MM slave port.
`timescale 1ns/1ps
module hct_transfer_control
    import hct_pkg::*;
(
    input wire logic mclk,
    input wire logic reset,
    input wire logic [ADDR_W-1:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    output logic [31:0] readdata,
    output logic waitrequest,
    output logic irq,
    output logic txnRequest,
    output logic [1:0] tokenKind,
    output logic [1:0] transferKind,
    output logic [9:0] maxPacket,
    output logic [9:0] txnLength,
    output logic dataToggle,
    input wire logic txnDone,
    input wire logic [9:0] txnBytes,
    input wire logic txnToggle,
    input wire logic [2:0] txnResult
);

    // ------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------
    logic running;
    logic stopPending;
    logic zeroPending;
    logic [7:0] setup;
    logic [31:0] remaining;
    logic [EVT_W-1:0] status;
    logic [EVT_W-1:0] mask;
    logic [2:0] resultCode;
    hct_state_type state;

    logic [8:0] index;
    logic writeHit;
    logic goWrite;
    logic stopWrite;
    logic [31:0] next_remaining;
    logic countDone;
    logic fullPacket;
    logic txnFail;
    logic finishNow;
    logic appendZero;
    logic stopDone;
    logic [EVT_W-1:0] eventSet;
    logic [31:0] next_readdata;

    assign index = address[ADDR_W-1:IDX_LSB];
    // The write lands at the edge where the master sees waitrequest low
    assign writeHit = write && !waitrequest;
    assign goWrite = writeHit && index == IDX_RUN_CONTROL && writedata[RUN_GO_BIT];
    assign stopWrite = writeHit && index == IDX_RUN_CONTROL && !writedata[RUN_GO_BIT] && running;

    // ------------------------------------------------------------
    // Completion decode
    // ------------------------------------------------------------
    assign next_remaining = (remaining > {22'h000000, txnBytes}) ? remaining - {22'h000000, txnBytes}
                                                               : COUNT_RESET;
    assign txnFail = txnResult != RESULT_OK;
    assign countDone = !setup[SETUP_UNLIMITED_BIT] && next_remaining == COUNT_RESET;
    assign fullPacket = txnBytes == maxPacket && maxPacket != LIMIT_RESET;
    // Only OUT tokens append the trailing empty packet
    assign appendZero = setup[SETUP_AUTO_ZERO_BIT] && tokenKind == TOKEN_OUT
                        && fullPacket && !zeroPending;
    assign finishNow = state == CH_BUSY && txnDone && !txnFail && countDone && !appendZero;
    // Stop with nothing in flight flags at once; otherwise at the in-flight end
    assign stopDone = (stopPending && state == CH_IDLE)
                      || (stopPending && state == CH_BUSY && txnDone && !txnFail && !finishNow);
    assign eventSet[EVT_COMPLETE_BIT] = finishNow;
    assign eventSet[EVT_CHANGE_BIT] = (state == CH_BUSY && txnDone && txnFail) || stopDone;

    // ------------------------------------------------------------
    // Bus handshake
    // ------------------------------------------------------------
    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            waitrequest <= 1'b1;
        end
        else
        begin
            waitrequest <= !((read || write) && waitrequest);
        end
    end

    always_comb
    begin
        next_readdata = 32'h0000_0000;
        case (index)
            IDX_RUN_CONTROL: next_readdata[RUN_TOGGLE_BIT:RUN_GO_BIT] = {dataToggle, running};
            IDX_TRANSFER_SETUP: next_readdata[7:0] = setup;
            IDX_LIMIT_HIGH: next_readdata[LIMIT_HIGH_W-1:0] = maxPacket[9:8];
            IDX_LIMIT_LOW: next_readdata[7:0] = maxPacket[7:0];
            IDX_BYTE_COUNT: next_readdata = remaining;
            IDX_EVENT_STATUS: next_readdata[EVT_W-1:0] = status;
            IDX_EVENT_MASK: next_readdata[EVT_W-1:0] = mask;
            IDX_RESULT_CODE: next_readdata[RESULT_LSB+2:RESULT_LSB] = resultCode;
            default: next_readdata = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            readdata <= 32'h0000_0000;
        end
        else if (read && waitrequest)
        begin
            readdata <= next_readdata;
        end
    end

    // ------------------------------------------------------------
    // Channel settings
    // ------------------------------------------------------------
    // Settings are never touched by a stop, so a resume sees them intact
    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            setup <= SETUP_RESET;
            maxPacket <= LIMIT_RESET;
        end
        else if (writeHit && index == IDX_TRANSFER_SETUP)
        begin
            setup <= writedata[7:0] & 8'hF9;
        end
        else if (writeHit && index == IDX_LIMIT_HIGH)
        begin
            maxPacket[9:8] <= writedata[LIMIT_HIGH_W-1:0];
        end
        else if (writeHit && index == IDX_LIMIT_LOW)
        begin
            maxPacket[7:0] <= writedata[7:0];
        end
    end

    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            tokenKind <= 2'h0;
            transferKind <= 2'h0;
        end
        else
        begin
            tokenKind <= setup[SETUP_TOKEN_LSB+1:SETUP_TOKEN_LSB];
            transferKind <= setup[SETUP_KIND_LSB+1:SETUP_KIND_LSB];
        end
    end

    // ------------------------------------------------------------
    // Data toggle
    // ------------------------------------------------------------
    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            dataToggle <= 1'b0;
        end
        else if (state == CH_BUSY && txnDone)
        begin
            dataToggle <= txnToggle;
        end
        // Gap cycles between transactions must not overwrite the live toggle
        else if (writeHit && index == IDX_RUN_CONTROL && state == CH_IDLE && !running)
        begin
            dataToggle <= writedata[RUN_TOGGLE_BIT];
        end
    end

    // ------------------------------------------------------------
    // Byte count
    // ------------------------------------------------------------
    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            remaining <= COUNT_RESET;
        end
        else if (state == CH_BUSY && txnDone && !txnFail && !setup[SETUP_UNLIMITED_BIT])
        begin
            remaining <= next_remaining;
        end
        else if (writeHit && index == IDX_BYTE_COUNT && !running && state == CH_IDLE)
        begin
            remaining <= writedata;
        end
    end

    // ------------------------------------------------------------
    // Run control
    // ------------------------------------------------------------
    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            running <= 1'b0;
            stopPending <= 1'b0;
        end
        // A redundant go never outlives a same-cycle completion
        else if (goWrite && !(running && eventSet != '0))
        begin
            running <= 1'b1;
            stopPending <= 1'b0;
        end
        else if (stopWrite)
        begin
            running <= 1'b0;
            stopPending <= 1'b1;
        end
        else if (eventSet != '0)
        begin
            running <= 1'b0;
            stopPending <= 1'b0;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            zeroPending <= 1'b0;
        end
        else if (state == CH_BUSY && txnDone)
        begin
            zeroPending <= !txnFail && countDone && appendZero;
        end
    end

    // ------------------------------------------------------------
    // Transaction sequencer
    // ------------------------------------------------------------
    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            state <= CH_IDLE;
            txnRequest <= 1'b0;
            txnLength <= LIMIT_RESET;
        end
        else
        begin
            case (state)
                CH_IDLE:
                begin
                    if (running && !stopPending && !stopWrite)
                    begin
                        state <= CH_BUSY;
                        txnRequest <= 1'b1;
                        if (zeroPending || (remaining == COUNT_RESET && !setup[SETUP_UNLIMITED_BIT]))
                        begin
                            txnLength <= LIMIT_RESET;
                        end
                        else if (setup[SETUP_UNLIMITED_BIT] || remaining >= {22'h000000, maxPacket})
                        begin
                            txnLength <= maxPacket;
                        end
                        else
                        begin
                            txnLength <= remaining[9:0];
                        end
                    end
                end
                CH_BUSY:
                begin
                    // In-flight transaction always runs to its end
                    if (txnDone)
                    begin
                        state <= CH_IDLE;
                        txnRequest <= 1'b0;
                    end
                end
                default:
                begin
                    state <= CH_IDLE;
                    txnRequest <= 1'b0;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Result code
    // ------------------------------------------------------------
    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            resultCode <= RESULT_OK;
        end
        else if (state == CH_BUSY && txnDone)
        begin
            resultCode <= txnResult;
        end
    end

    // ------------------------------------------------------------
    // Events and interrupt
    // ------------------------------------------------------------
    // Hardware set wins over a same-cycle write-one clear
    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            status <= '0;
        end
        else if (writeHit && index == IDX_EVENT_STATUS)
        begin
            status <= (status & ~writedata[EVT_W-1:0]) | eventSet;
        end
        else
        begin
            status <= status | eventSet;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            mask <= '0;
        end
        else if (writeHit && index == IDX_EVENT_MASK)
        begin
            mask <= writedata[EVT_W-1:0];
        end
    end

    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            irq <= 1'b0;
        end
        else
        begin
            irq <= |(status & mask);
        end
    end

endmodule

/* rtl/hct_pkg.sv */
package hct_pkg;

    // ------------------------------------------------------------
    // Register indices (byte address is four times the index)
    // ------------------------------------------------------------
    localparam logic [8:0] IDX_RUN_CONTROL = 9'h1B0;
    localparam logic [8:0] IDX_TRANSFER_SETUP = 9'h1B1;
    localparam logic [8:0] IDX_LIMIT_HIGH = 9'h1B2;
    localparam logic [8:0] IDX_LIMIT_LOW = 9'h1B3;
    localparam logic [8:0] IDX_BYTE_COUNT = 9'h1B4;
    localparam logic [8:0] IDX_EVENT_STATUS = 9'h1BC;
    localparam logic [8:0] IDX_EVENT_MASK = 9'h1BD;
    localparam logic [8:0] IDX_RESULT_CODE = 9'h1BE;

    localparam int ADDR_W = 11;
    localparam int IDX_LSB = 2;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int RUN_GO_BIT = 0;
    localparam int RUN_TOGGLE_BIT = 1;
    localparam int SETUP_UNLIMITED_BIT = 0;
    localparam int SETUP_AUTO_ZERO_BIT = 3;
    localparam int SETUP_KIND_LSB = 4;
    localparam int SETUP_TOKEN_LSB = 6;
    localparam int LIMIT_HIGH_W = 2;
    localparam int RESULT_LSB = 4;
    localparam int EVT_COMPLETE_BIT = 0;
    localparam int EVT_CHANGE_BIT = 1;
    localparam int EVT_W = 2;

    // ------------------------------------------------------------
    // Reset values and codes
    // ------------------------------------------------------------
    localparam logic [7:0] SETUP_RESET = 8'h00;
    localparam logic [9:0] LIMIT_RESET = 10'h000;
    localparam logic [31:0] COUNT_RESET = 32'h0000_0000;
    localparam logic [1:0] TOKEN_OUT = 2'h1;
    localparam logic [1:0] TOKEN_IN = 2'h2;
    localparam logic [1:0] KIND_BULK = 2'h2;
    localparam logic [1:0] KIND_INTERRUPT = 2'h3;

    typedef enum logic [2:0] {
        RESULT_OK = 3'b000,
        RESULT_STALL = 3'b001,
        RESULT_OVERRUN = 3'b010,
        RESULT_UNDERRUN = 3'b011,
        RESULT_RETRY = 3'b100
    } hct_result_type;

    typedef enum logic [0:0] {
        CH_IDLE = 1'b0,
        CH_BUSY = 1'b1
    } hct_state_type;

endpackage

/* test/hct_monitor.sv */
`timescale 1ns/1ps
module hct_monitor
    import hct_pkg::*;
(
    input wire logic mclk,
    input wire logic reset,
    input wire logic [ADDR_W-1:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic waitrequest,
    input wire logic irq,
    input wire logic txnRequest,
    input wire logic [1:0] tokenKind,
    input wire logic [1:0] transferKind,
    input wire logic [9:0] txnLength,
    input wire logic dataToggle,
    input wire logic txnDone,
    input wire logic txnToggle
);
    // ------------------------------------------------------------
    // Bus and transaction checks
    // ------------------------------------------------------------
    default clocking @(posedge mclk); endclocking
    default disable iff (reset);
    logic runWr;
    logic setupAck;
    assign runWr = write && waitrequest && address[ADDR_W-1:IDX_LSB] == IDX_RUN_CONTROL;
    assign setupAck = write && !waitrequest && address[ADDR_W-1:IDX_LSB] == IDX_TRANSFER_SETUP;

    bus_answer_a: assert property ((read || write) && waitrequest |=> !waitrequest)
        else $error("bus request not answered in one cycle");
    bus_release_a: assert property (!waitrequest |=> waitrequest)
        else $error("waitrequest low for more than one cycle");
    req_stands_a: assert property (txnRequest && !txnDone |=> txnRequest && $stable(txnLength))
        else $error("transaction request dropped or length changed early");
    toggle_track_a: assert property (txnRequest && txnDone |=> !txnRequest && dataToggle == $past(txnToggle))
        else $error("toggle not taken from finished transaction");
    go_start_a: assert property (runWr && writedata[RUN_GO_BIT] && !txnRequest && tokenKind == TOKEN_OUT
        |-> ##[1:4] txnRequest)
        else $error("go write did not start a transaction");
    stop_quiet_a: assert property (runWr && !writedata[RUN_GO_BIT] && !txnRequest ##1 !txnRequest [*2]
        |=> !txnRequest [*4])
        else $error("transaction issued after stop");
    irq_cause_a: assert property ($rose(irq) |-> $past(txnDone, 2) || $past(write && !waitrequest, 2)
        || $past(write && !waitrequest, 3))
        else $error("interrupt rose without an event");
    kind_copy_a: assert property (setupAck |-> ##2 transferKind == $past(writedata[5:4], 2)
        && tokenKind == $past(writedata[7:6], 2))
        else $error("token or transfer kind not following setup");

    cover property (txnRequest && txnDone);
    cover property ($rose(irq));
    cover property (runWr && !writedata[RUN_GO_BIT] && txnRequest);
endmodule
bind hct_transfer_control hct_monitor u_hct_monitor (.mclk(mclk), .reset(reset), .address(address),
    .read(read), .write(write), .writedata(writedata), .waitrequest(waitrequest), .irq(irq),
    .txnRequest(txnRequest), .tokenKind(tokenKind), .transferKind(transferKind), .txnLength(txnLength),
    .dataToggle(dataToggle), .txnDone(txnDone), .txnToggle(txnToggle));

/* test/hct_engine_model.sv */
`timescale 1ns/1ps
module hct_engine_model (
    input wire logic mclk,
    input wire logic reset,
    input wire logic txnRequest,
    input wire logic [9:0] txnLength,
    input wire logic dataToggle,
    input wire logic [7:0] delay,
    input wire logic [2:0] resultCode,
    output logic txnDone,
    output logic [9:0] txnBytes,
    output logic txnToggle,
    output logic [2:0] txnResult
);
    logic [7:0] waitCount;
    always_ff @(posedge mclk)
    begin
        if (reset || txnDone || !txnRequest)
        begin
            // Qualifiers scrambled outside the pulse so stale values never match
            txnDone <= 1'b0;
            waitCount <= 8'h00;
            txnBytes <= reset ? 10'h000 : ~txnBytes;
            txnToggle <= reset ? 1'b0 : ~txnToggle;
            txnResult <= reset ? 3'h0 : ~txnResult;
        end
        else if (waitCount == delay)
        begin
            txnDone <= 1'b1;
            txnBytes <= txnLength;
            txnToggle <= ~dataToggle;
            txnResult <= resultCode;
        end
        else
            waitCount <= waitCount + 8'h01;
    end
endmodule

/* test/hct_transfer_control_tb.sv */
`timescale 1ns/1ps
module hct_transfer_control_tb import hct_pkg::*;;
    logic mclk, reset, read, write, irq, waitrequest, txnRequest, dataToggle, txnDone, txnToggle, firstTgl;
    logic [ADDR_W-1:0] address;
    logic [31:0] writedata, readdata, rd, lfsr;
    logic [9:0] maxPacket, txnLength, txnBytes, lastLen;
    logic [1:0] tokenKind, transferKind;
    logic [2:0] txnResult, resultCode, lastRes;
    logic [7:0] delay;
    logic [8:0] ridx [6];
    int mismatches, checks, cycles, txnCount, base;

    hct_transfer_control u_hct_transfer_control (.mclk(mclk), .reset(reset), .address(address), .read(read),
        .write(write), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest), .irq(irq),
        .txnRequest(txnRequest), .tokenKind(tokenKind), .transferKind(transferKind), .maxPacket(maxPacket),
        .txnLength(txnLength), .dataToggle(dataToggle), .txnDone(txnDone), .txnBytes(txnBytes),
        .txnToggle(txnToggle), .txnResult(txnResult));
    hct_engine_model u_hct_engine_model (.mclk(mclk), .reset(reset), .txnRequest(txnRequest),
        .txnLength(txnLength), .dataToggle(dataToggle), .delay(delay), .resultCode(resultCode),
        .txnDone(txnDone), .txnBytes(txnBytes), .txnToggle(txnToggle), .txnResult(txnResult));

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] nextRand(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic int expTxns(input int cnt, input int mp, input logic out, input logic az);
        int n;
        n = (cnt + mp - 1) / mp;
        if (out && (cnt == 0 || (az && cnt % mp == 0)))
            n++;
        return n;
    endfunction
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic bus(input logic wr, input logic [8:0] idx, input logic [31:0] wd);
        address <= {idx, 2'b00};
        write <= wr;
        read <= !wr;
        writedata <= wd;
        @(posedge mclk);
        while (waitrequest !== 1'b0)
            @(posedge mclk);
        rd = readdata;
        read <= 1'b0;
        write <= 1'b0;
        @(posedge mclk);
    endtask
    task automatic end_sim;
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    initial
    begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end
    always @(posedge mclk)
    begin
        cycles <= cycles + 1;
        if (txnRequest && txnDone)
        begin
            txnCount <= txnCount + 1;
            lastLen <= txnLength;
            lastRes <= txnResult;
            if (txnCount == base)
                firstTgl <= dataToggle;
        end
        if (cycles > 20000)
        begin
            mismatches++;
            end_sim();
        end
    end

    initial
    begin
        int n, n0, cnt, mp;
        logic out, az, tgl;
        logic [7:0] setup;
        {reset, read, write, address, writedata, delay, resultCode} = {1'b1, 56'h0};
        {mismatches, checks, cycles, txnCount, base} = {5{32'h0}};
        lfsr = 32'hA7A278CC;
        ridx = '{IDX_RUN_CONTROL, IDX_TRANSFER_SETUP, IDX_LIMIT_HIGH, IDX_LIMIT_LOW, IDX_EVENT_STATUS, 9'h1B5};
        repeat (8) @(posedge mclk);
        reset <= 1'b0;
        @(posedge mclk);
        foreach (ridx[i])
        begin
            bus(0, ridx[i], 0);
            check("reset value", rd, 32'h0);
        end
        bus(1, 9'h1B5, 32'hFF);
        bus(0, 9'h1B5, 0);
        check("unmapped", rd, 32'h0);
        bus(1, IDX_EVENT_MASK, 32'h3);
        $display("reset test done");
        for (int t = 0; t < 6; t++)
        begin
            lfsr = nextRand(nextRand(lfsr));
            {out, az, tgl, mp} = {lfsr[0], lfsr[1], lfsr[2], 32'h8 << lfsr[4:3]};
            cnt = mp * (1 + lfsr[5]) + (lfsr[6] ? 0 : int'(lfsr[9:7]));
            if (t == 0)
                {out, az, cnt} = {2'b11, 32'(2 * mp)};
            if (t == 1)
                {out, cnt} = {1'b1, 32'h0};
            setup = {out ? TOKEN_OUT : TOKEN_IN, lfsr[10] ? KIND_BULK : KIND_INTERRUPT, az, 3'b000};
            delay <= (t == 0) ? 8'h1E : {5'h0, lfsr[13:11]};
            bus(1, IDX_TRANSFER_SETUP, {24'h0, setup | 8'h06});
            bus(0, IDX_TRANSFER_SETUP, 0);
            check("setup", rd, {24'h0, setup});
            bus(1, IDX_LIMIT_HIGH, 32'(mp >> 8));
            bus(1, IDX_LIMIT_LOW, 32'(mp & 255));
            bus(1, IDX_BYTE_COUNT, 32'(cnt));
            bus(1, IDX_RUN_CONTROL, {30'h0, tgl, 1'b0});
            bus(1, IDX_EVENT_STATUS, 32'h3);
            check("max packet", {22'h0, maxPacket}, 32'(mp));
            check("kinds", {28'h0, tokenKind, transferKind}, {28'h0, setup[7:4]});
            n = expTxns(cnt, mp, out, az);
            n0 = txnCount;
            base = n0;
            bus(1, IDX_RUN_CONTROL, {30'h0, tgl, 1'b1});
            if (t == 0)
                bus(1, IDX_RUN_CONTROL, {30'h0, tgl, 1'b1});
            while (txnCount < n0 + n)
                @(posedge mclk);
            repeat (30) @(posedge mclk);
            check("txn count", 32'(txnCount - n0), 32'(n));
            check("first toggle", {31'h0, firstTgl}, {31'h0, tgl});
            if (n > (cnt + mp - 1) / mp)
                check("zero length", {22'h0, lastLen}, 32'h0);
            else
                check("last length", {22'h0, lastLen}, 32'(cnt - (n - 1) * mp));
            bus(0, IDX_RUN_CONTROL, 0);
            check("run", rd, {30'h0, tgl ^ n[0], 1'b0});
            bus(0, IDX_EVENT_STATUS, 0);
            check("status", rd, 32'h1);
            check("irq set", {31'h0, irq}, 32'h1);
            bus(1, IDX_EVENT_STATUS, 32'h1);
            repeat (2) @(posedge mclk);
            check("irq clear", {31'h0, irq}, 32'h0);
        end
        $display("random transfer test done");
        delay <= 8'h0F;
        bus(1, IDX_TRANSFER_SETUP, {24'h0, TOKEN_OUT, KIND_BULK, 4'h0});
        bus(1, IDX_LIMIT_LOW, 32'h8);
        bus(1, IDX_BYTE_COUNT, 32'h18);
        n0 = txnCount;
        bus(1, IDX_RUN_CONTROL, 32'h1);
        while (txnCount < n0 + 1)
            @(posedge mclk);
        bus(1, IDX_RUN_CONTROL, 32'h0);
        bus(0, IDX_RUN_CONTROL, 0);
        check("go after stop", rd & 32'h1, 32'h0);
        repeat (40) @(posedge mclk);
        check("in flight finished", 32'(txnCount - n0), 32'h2);
        bus(0, IDX_EVENT_STATUS, 0);
        check("change flag", rd, 32'h2);
        bus(0, IDX_BYTE_COUNT, 0);
        check("remaining", rd, 32'h8);
        bus(1, IDX_EVENT_STATUS, 32'h3);
        bus(0, IDX_RUN_CONTROL, 0);
        bus(1, IDX_RUN_CONTROL, rd | 32'h1);
        repeat (30) @(posedge mclk);
        bus(0, IDX_EVENT_STATUS, 0);
        check("resumed status", {30'h0, rd[1:0]}, 32'h1);
        check("resumed count", 32'(txnCount - n0), 32'h3);
        $display("stop and resume test done");
        delay <= 8'h02;
        bus(1, IDX_EVENT_MASK, 32'h1);
        bus(1, IDX_EVENT_STATUS, 32'h3);
        bus(1, IDX_TRANSFER_SETUP, {24'h0, TOKEN_IN, KIND_INTERRUPT, 4'h1});
        n0 = txnCount;
        bus(1, IDX_RUN_CONTROL, 32'h1);
        while (txnCount < n0 + 3)
            @(posedge mclk);
        bus(0, IDX_RUN_CONTROL, 0);
        check("unlimited", rd & 32'h1, 32'h1);
        for (int c = 1; c < 5; c++)
        begin
            bus(0, IDX_RUN_CONTROL, 0);
            bus(1, IDX_RUN_CONTROL, rd | 32'h1);
            resultCode <= 3'(c);
            while (lastRes !== 3'(c))
                @(posedge mclk);
            repeat (3) @(posedge mclk);
            bus(0, IDX_RUN_CONTROL, 0);
            check("go on error", rd & 32'h1, 32'h0);
            bus(0, IDX_RESULT_CODE, 0);
            check("result code", rd, 32'(c << RESULT_LSB));
            bus(0, IDX_EVENT_STATUS, 0);
            check("masked irq", {rd[1], irq}, 2'b10);
            bus(1, IDX_EVENT_STATUS, 32'h3);
        end
        $display("error code test done");
        end_sim();
    end
endmodule
